// *** design/pmicir_pkg.sv ***
// constants shared by the interrupt collection block: register map, field layout, timing
// assumes a single 100 MHz clock and a register access port driven by the serial frontend
// Function
// RQ1: interrupt output low while any factor pending
// RQ2: summary bits D0-D3 flag pending groups
// RQ3: D4 self-diagnosis failure, group bit also set
// RQ4: D5 reset cause, clears after all factors clear
// RQ5: reset output never reinitialises request registers
// RQ6: group one holds over-voltage flags D0-D6
// RQ7: self-diagnosis failure sets block's request flag
// RQ8: group two holds eight low-voltage flags
// RQ9: second regulator low-voltage flag survives reset
// RQ10: group three holds seven miscellaneous fault flags
// RQ11: group four read-only except writable test bit
// RQ12: host clears test bit, then test clear
// RQ13: clear one: write one clears, zero keeps
// RQ14: empty group drops its summary bit
// RQ15: clear two to four work the same way
// RQ16: four mask registers, one masks, default zero
// RQ17: masked factor never asserts interrupt output
// RQ18: 500 us hold-off after clear, then reassert
// RQ19: host clears every factor that caused assertion
// RQ20: output released when no unmasked flag pending
package pmicir_pkg;

  // ----------------------------------------------------------------
  // register addresses (six address bits)
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_SUMMARY = 6'h03;
  localparam logic [5:0] ADDR_REQ1 = 6'h04;
  localparam logic [5:0] ADDR_REQ2 = 6'h05;
  localparam logic [5:0] ADDR_REQ3 = 6'h06;
  localparam logic [5:0] ADDR_REQ4 = 6'h07;
  localparam logic [5:0] ADDR_CLR1 = 6'h08;
  localparam logic [5:0] ADDR_CLR2 = 6'h09;
  localparam logic [5:0] ADDR_CLR3 = 6'h0a;
  localparam logic [5:0] ADDR_CLR4 = 6'h0b;
  localparam logic [5:0] ADDR_MSK1 = 6'h0c;
  localparam logic [5:0] ADDR_MSK2 = 6'h0d;
  localparam logic [5:0] ADDR_MSK3 = 6'h0e;
  localparam logic [5:0] ADDR_MSK4 = 6'h0f;

  // ----------------------------------------------------------------
  // implemented bits of each group
  // ----------------------------------------------------------------
  localparam logic [7:0] REQ1_BITS = 8'h7f;
  localparam logic [7:0] REQ2_BITS = 8'hff;
  localparam logic [7:0] REQ3_BITS = 8'h7f;
  localparam logic [7:0] REQ4_BITS = 8'hff;
  localparam logic [7:0] MSK1_BITS = 8'h7f;
  localparam logic [7:0] MSK2_BITS = 8'hff;
  localparam logic [7:0] MSK3_BITS = 8'h77;
  localparam logic [7:0] MSK4_BITS = 8'hef;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int TEST_BIT = 7;
  localparam int SUM_SELFCHK = 4;
  localparam int SUM_RSTCAUSE = 5;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic MASK_RESET = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLDOFF_US = 500;
  localparam int HOLDOFF_CYCLES = (HOLDOFF_US * 1000) / CLK_PERIOD_NS;
  localparam int HOLD_W = 20;
  localparam logic [HOLD_W-1:0] HOLD_IDLE = 20'h00000;

endpackage

// *** design/pmicir_req_group.sv ***
// one request group: synchronised factor inputs, sticky flags, write-one clear
// assumes detector inputs are asynchronous levels and the clear vector is a one-cycle pulse
`timescale 1ns/1ps
module pmicir_req_group #(
  parameter logic [7:0] VALID = 8'hff
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // factor sources
  input wire logic [7:0] evt_async,
  input wire logic [7:0] diag_async,
  input wire logic [7:0] set_local,
  // host clear
  input wire logic [7:0] clr,
  // state
  output logic [7:0] flags,
  output logic diag_hit
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] evt_s1;
    logic [7:0] evt_s2;
    logic [7:0] diag_s1;
    logic [7:0] diag_s2;
    logic [7:0] flags;
  } pmicir_grp_t;

  pmicir_grp_t st_q;
  pmicir_grp_t st_d;
  logic [7:0] set_vec;

  assign set_vec = (st_q.evt_s2 | st_q.diag_s2 | set_local) & VALID; // [RQ7]

  always_comb
  begin
    st_d = st_q;
    st_d.evt_s1 = evt_async;
    st_d.evt_s2 = st_q.evt_s1;
    st_d.diag_s1 = diag_async;
    st_d.diag_s2 = st_q.diag_s1;
    // a persisting factor sets its flag again right after a clear; set wins
    st_d.flags = ((st_q.flags & ~clr) | set_vec) & VALID; // [RQ13] [RQ15]
  end

  // apart from host clears, only the power-on reset clears flags; the reset output never reaches here
  always_ff @(posedge sys_clk or posedge rst) // [RQ5] [RQ9]
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;
  assign diag_hit = |(st_q.diag_s2 & VALID);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_clear_one;
    @(posedge sys_clk) disable iff (rst)
    (clr[0] && !set_vec[0]) |=> !st_q.flags[0];
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("clear did not drop flag"); // [RQ13]

  property p_set_wins;
    @(posedge sys_clk) disable iff (rst)
    (clr != 8'h00 && set_vec != 8'h00) |=> ((st_q.flags & $past(set_vec)) == $past(set_vec));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost against clear"); // [RQ15]

endmodule

// *** design/pmicir_top.sv ***
// interrupt collection: four request groups, factor summary, masks, hold-off, interrupt pin
// assumes the serial frontend presents decoded register accesses as one-cycle strobes on sys_clk
`timescale 1ns/1ps
module pmicir_top #(
  parameter int unsigned HOLDOFF_CYCLES = pmicir_pkg::HOLDOFF_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register access port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // detector factors, asynchronous levels
  input wire logic [6:0] ovp_evt,
  input wire logic [7:0] uvp_evt,
  input wire logic [6:0] misc_evt,
  input wire logic [6:0] diag_evt,
  // self-diagnosis failures per block, asynchronous levels
  input wire logic [6:0] ovp_diag,
  input wire logic [7:0] uvp_diag,
  input wire logic [6:0] misc_diag,
  input wire logic [6:0] diag_diag,
  // reset factor present, asynchronous level
  input wire logic reset_cause,
  // interrupt pin
  output logic irq_out_n
);

  localparam logic [pmicir_pkg::HOLD_W-1:0] HOLD_LOAD = HOLDOFF_CYCLES[pmicir_pkg::HOLD_W-1:0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] mask3;
    logic [7:0] mask4;
    logic test_bit;
    logic selfchk;
    logic rstcause;
    logic [1:0] rc_sync;
    logic [pmicir_pkg::HOLD_W-1:0] hold;
    logic irq_n;
    logic [7:0] rdata;
    logic rvalid;
  } pmicir_state_t;

  pmicir_state_t st_q;
  pmicir_state_t st_d;

  logic [7:0] flags1;
  logic [7:0] flags2;
  logic [7:0] flags3;
  logic [7:0] flags4;
  logic [3:0] diag_hit;
  logic [7:0] clr1;
  logic [7:0] clr2;
  logic [7:0] clr3;
  logic [7:0] clr4;
  logic [7:0] summary;
  logic any_flag;
  logic any_unmasked;
  logic clear_event;

  // ----------------------------------------------------------------
  // write-one clear strobes
  // ----------------------------------------------------------------
  assign clr1 = (reg_wr && reg_addr == pmicir_pkg::ADDR_CLR1) ? reg_wdata : 8'h00; // [RQ13]
  assign clr2 = (reg_wr && reg_addr == pmicir_pkg::ADDR_CLR2) ? reg_wdata : 8'h00; // [RQ15]
  assign clr3 = (reg_wr && reg_addr == pmicir_pkg::ADDR_CLR3) ? reg_wdata : 8'h00; // [RQ15]
  assign clr4 = (reg_wr && reg_addr == pmicir_pkg::ADDR_CLR4) ? reg_wdata : 8'h00; // [RQ15] [RQ12]

  // any write that clears at least one implemented bit starts the hold-off
  assign clear_event = |(clr1 & pmicir_pkg::REQ1_BITS) | |(clr2 & pmicir_pkg::REQ2_BITS)
                     | |(clr3 & pmicir_pkg::REQ3_BITS) | |(clr4 & pmicir_pkg::REQ4_BITS);

  // ----------------------------------------------------------------
  // request groups
  // ----------------------------------------------------------------
  pmicir_req_group #(
    .VALID(pmicir_pkg::REQ1_BITS)
  ) u_grp1 ( // [RQ6]
    .sys_clk(sys_clk),
    .rst(rst),
    .evt_async({1'b0, ovp_evt}),
    .diag_async({1'b0, ovp_diag}),
    .set_local(8'h00),
    .clr(clr1),
    .flags(flags1),
    .diag_hit(diag_hit[0])
  );

  pmicir_req_group #(
    .VALID(pmicir_pkg::REQ2_BITS)
  ) u_grp2 ( // [RQ8] [RQ9]
    .sys_clk(sys_clk),
    .rst(rst),
    .evt_async(uvp_evt),
    .diag_async(uvp_diag),
    .set_local(8'h00),
    .clr(clr2),
    .flags(flags2),
    .diag_hit(diag_hit[1])
  );

  pmicir_req_group #(
    .VALID(pmicir_pkg::REQ3_BITS)
  ) u_grp3 ( // [RQ10]
    .sys_clk(sys_clk),
    .rst(rst),
    .evt_async({1'b0, misc_evt}),
    .diag_async({1'b0, misc_diag}),
    .set_local(8'h00),
    .clr(clr3),
    .flags(flags3),
    .diag_hit(diag_hit[2])
  );

  // the test bit keeps setting its flag until the host writes it back to zero
  pmicir_req_group #(
    .VALID(pmicir_pkg::REQ4_BITS)
  ) u_grp4 ( // [RQ11]
    .sys_clk(sys_clk),
    .rst(rst),
    .evt_async({1'b0, diag_evt}),
    .diag_async({1'b0, diag_diag}),
    .set_local({st_q.test_bit, 7'h00}),
    .clr(clr4),
    .flags(flags4),
    .diag_hit(diag_hit[3])
  );

  // ----------------------------------------------------------------
  // summary and interrupt decision
  // ----------------------------------------------------------------
  assign any_flag = |flags1 | |flags2 | |flags3 | |flags4;
  assign any_unmasked = |(flags1 & ~st_q.mask1) | |(flags2 & ~st_q.mask2)
                      | |(flags3 & ~st_q.mask3) | |(flags4 & ~st_q.mask4); // [RQ17]

  always_comb
  begin
    summary = pmicir_pkg::BYTE_RESET;
    summary[0] = |flags1; // [RQ2] [RQ14]
    summary[1] = |flags2; // [RQ2] [RQ14]
    summary[2] = |flags3; // [RQ2] [RQ14]
    summary[3] = |flags4; // [RQ2] [RQ14]
    summary[pmicir_pkg::SUM_SELFCHK] = st_q.selfchk; // [RQ3]
    summary[pmicir_pkg::SUM_RSTCAUSE] = st_q.rstcause; // [RQ4]
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.rc_sync[0] = reset_cause;
    st_d.rc_sync[1] = st_q.rc_sync[0];
    // sticky summary flags drop only with the last request; a new set wins
    st_d.selfchk = (|diag_hit) | (st_q.selfchk & any_flag); // [RQ3]
    st_d.rstcause = st_q.rc_sync[1] | (st_q.rstcause & any_flag); // [RQ4]
    if (reg_wr)
    begin
      case (reg_addr)
        pmicir_pkg::ADDR_REQ4: st_d.test_bit = reg_wdata[pmicir_pkg::TEST_BIT]; // [RQ11]
        pmicir_pkg::ADDR_MSK1: st_d.mask1 = reg_wdata & pmicir_pkg::MSK1_BITS; // [RQ16]
        pmicir_pkg::ADDR_MSK2: st_d.mask2 = reg_wdata & pmicir_pkg::MSK2_BITS; // [RQ16]
        pmicir_pkg::ADDR_MSK3: st_d.mask3 = reg_wdata & pmicir_pkg::MSK3_BITS; // [RQ16]
        pmicir_pkg::ADDR_MSK4: st_d.mask4 = reg_wdata & pmicir_pkg::MSK4_BITS; // [RQ16]
        default: st_d.test_bit = st_q.test_bit;
      endcase
    end
    // hold-off: restarted by every clear, counts down to idle
    if (clear_event)
    begin
      st_d.hold = HOLD_LOAD; // [RQ18]
    end
    else if (st_q.hold != pmicir_pkg::HOLD_IDLE)
    begin
      st_d.hold = st_q.hold - 1'b1;
    end
    // pin stays released during hold-off even if a factor persists
    st_d.irq_n = !(any_unmasked && !clear_event && st_q.hold == pmicir_pkg::HOLD_IDLE); // [RQ1] [RQ18] [RQ20]
    st_d.rvalid = reg_rd;
    if (reg_rd)
    begin
      case (reg_addr)
        pmicir_pkg::ADDR_SUMMARY: st_d.rdata = summary; // [RQ2]
        pmicir_pkg::ADDR_REQ1: st_d.rdata = flags1; // [RQ6]
        pmicir_pkg::ADDR_REQ2: st_d.rdata = flags2; // [RQ8]
        pmicir_pkg::ADDR_REQ3: st_d.rdata = flags3; // [RQ10]
        pmicir_pkg::ADDR_REQ4: st_d.rdata = {st_q.test_bit, flags4[6:0]}; // [RQ11]
        pmicir_pkg::ADDR_MSK1: st_d.rdata = st_q.mask1;
        pmicir_pkg::ADDR_MSK2: st_d.rdata = st_q.mask2;
        pmicir_pkg::ADDR_MSK3: st_d.rdata = st_q.mask3;
        pmicir_pkg::ADDR_MSK4: st_d.rdata = st_q.mask4;
        // clear registers are write-only; unmapped addresses read zero
        default: st_d.rdata = pmicir_pkg::BYTE_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // power-on reset only; the reset output must not wipe the collected causes
  always_ff @(posedge sys_clk or posedge rst) // [RQ5]
  begin
    if (rst)
    begin
      st_q.mask1 <= pmicir_pkg::BYTE_RESET;
      st_q.mask2 <= pmicir_pkg::BYTE_RESET;
      st_q.mask3 <= pmicir_pkg::BYTE_RESET;
      st_q.mask4 <= pmicir_pkg::BYTE_RESET;
      st_q.test_bit <= pmicir_pkg::MASK_RESET;
      st_q.selfchk <= 1'b0;
      st_q.rstcause <= 1'b0;
      st_q.rc_sync <= 2'h0;
      st_q.hold <= pmicir_pkg::HOLD_IDLE;
      st_q.irq_n <= 1'b1;
      st_q.rdata <= pmicir_pkg::BYTE_RESET;
      st_q.rvalid <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign irq_out_n = st_q.irq_n;
  assign reg_rdata = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_irq_assert;
    @(posedge sys_clk) disable iff (rst)
    (any_unmasked && !clear_event && st_q.hold == pmicir_pkg::HOLD_IDLE) |=> !irq_out_n;
  endproperty
  a_irq_assert: assert property (p_irq_assert) else $error("pending factor left pin high"); // [RQ1]

  property p_irq_release;
    @(posedge sys_clk) disable iff (rst)
    (!any_unmasked) |=> irq_out_n;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("pin low with nothing unmasked"); // [RQ20]

  property p_mask_blocks;
    @(posedge sys_clk) disable iff (rst)
    (any_flag && (flags1 & ~st_q.mask1) == 8'h00 && (flags2 & ~st_q.mask2) == 8'h00
      && (flags3 & ~st_q.mask3) == 8'h00 && (flags4 & ~st_q.mask4) == 8'h00) |=> irq_out_n;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked factor drove pin"); // [RQ17]

  property p_holdoff;
    @(posedge sys_clk) disable iff (rst)
    clear_event |=> irq_out_n [*8];
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("pin reasserted inside hold-off"); // [RQ18]

  property p_summary_read;
    @(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == pmicir_pkg::ADDR_SUMMARY)
      |=> reg_rvalid && reg_rdata[3:0] == {|$past(flags4), |$past(flags3), |$past(flags2), |$past(flags1)};
  endproperty
  a_summary_read: assert property (p_summary_read) else $error("summary group bits wrong"); // [RQ2]

  property p_req1_top_zero;
    @(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == pmicir_pkg::ADDR_REQ1) |=> !reg_rdata[7];
  endproperty
  a_req1_top_zero: assert property (p_req1_top_zero) else $error("reserved request bit set"); // [RQ6]

  property p_rstcause_hold;
    @(posedge sys_clk) disable iff (rst)
    (st_q.rstcause && any_flag) |=> st_q.rstcause;
  endproperty
  a_rstcause_hold: assert property (p_rstcause_hold) else $error("reset cause dropped early"); // [RQ4]

  property p_test_write;
    @(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == pmicir_pkg::ADDR_REQ4) |=> st_q.test_bit == $past(reg_wdata[7]);
  endproperty
  a_test_write: assert property (p_test_write) else $error("test bit not written"); // [RQ11]

  property p_test_sets;
    @(posedge sys_clk) disable iff (rst)
    st_q.test_bit |=> flags4[7];
  endproperty
  a_test_sets: assert property (p_test_sets) else $error("test bit gave no request"); // [RQ11]

  property p_mask_write;
    @(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == pmicir_pkg::ADDR_MSK3) |=> st_q.mask3 == ($past(reg_wdata) & pmicir_pkg::MSK3_BITS);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // [RQ16]

  property p_selfchk_set;
    @(posedge sys_clk) disable iff (rst)
    (|diag_hit) |=> st_q.selfchk;
  endproperty
  a_selfchk_set: assert property (p_selfchk_set) else $error("self-check flag missed"); // [RQ3]

  property p_rstcause_set;
    @(posedge sys_clk) disable iff (rst)
    st_q.rc_sync[1] |=> st_q.rstcause;
  endproperty
  a_rstcause_set: assert property (p_rstcause_set) else $error("reset cause not collected"); // [RQ4]

  property p_rstcause_clear;
    @(posedge sys_clk) disable iff (rst)
    (!any_flag && !st_q.rc_sync[1]) |=> !st_q.rstcause;
  endproperty
  a_rstcause_clear: assert property (p_rstcause_clear) else $error("reset cause stuck"); // [RQ4]

  property p_selfchk_clear;
    @(posedge sys_clk) disable iff (rst)
    (!any_flag && !(|diag_hit)) |=> !st_q.selfchk;
  endproperty
  a_selfchk_clear: assert property (p_selfchk_clear) else $error("self-check flag stuck"); // [RQ14]

  property p_req4_read;
    @(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == pmicir_pkg::ADDR_REQ4) |=> reg_rdata[7] == $past(st_q.test_bit);
  endproperty
  a_req4_read: assert property (p_req4_read) else $error("test bit read back wrong"); // [RQ11]

  property p_clr_read_zero;
    @(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr >= pmicir_pkg::ADDR_CLR1 && reg_addr <= pmicir_pkg::ADDR_CLR4) |=> reg_rdata == 8'h00;
  endproperty
  a_clr_read_zero: assert property (p_clr_read_zero) else $error("clear register readable"); // [RQ13]

  property p_hold_load;
    @(posedge sys_clk) disable iff (rst)
    clear_event |=> st_q.hold == HOLD_LOAD;
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("hold-off not restarted"); // [RQ18]

  property p_hold_pin;
    @(posedge sys_clk) disable iff (rst)
    (st_q.hold != pmicir_pkg::HOLD_IDLE) |=> irq_out_n;
  endproperty
  a_hold_pin: assert property (p_hold_pin) else $error("pin low while hold-off counts"); // [RQ18]

endmodule

// *** verif/pmicir_host.sv ***
// host side of the register access port: single-byte write and read cycles
// assumes the one-cycle strobe port of the interrupt block, sampled on sys_clk
`timescale 1ns/1ps
module pmicir_host (
  // clock
  input wire logic sys_clk,
  // register access port
  output logic [5:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial
  begin
    reg_addr = 6'h3f;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // released lines carry the inverse, so a stale byte never looks fresh
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (int i = 0; i < 3 && !ok; i++)
    begin
      if (reg_rvalid === 1'b1)
      begin
        d = reg_rdata;
        ok = 1'b1;
      end
      else
      begin
        @(posedge sys_clk);
        #1;
      end
    end
  endtask
endmodule

// *** verif/pmicir_test.sv ***
// self-checking bench of the interrupt collection block
// assumes a short hold-off parameter; the host model makes all register cycles
`timescale 1ns/1ps
module pmicir_test;
  // short hold-off keeps the run brief; the hold-off waits below are derived from it
  localparam int HOLD = 24;
  logic sys_clk;
  logic rst;
  logic [5:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [6:0] ovp_evt = 7'h00;
  logic [7:0] uvp_evt = 8'h00;
  logic [6:0] misc_evt = 7'h00;
  logic [6:0] diag_evt = 7'h00;
  logic [6:0] ovp_diag = 7'h00;
  logic [7:0] uvp_diag = 8'h00;
  logic [6:0] misc_diag = 7'h00;
  logic [6:0] diag_diag = 7'h00;
  logic reset_cause = 1'b0;
  logic irq_out_n;
  int err_count = 0;
  int cmp_count = 0;

  pmicir_top #(.HOLDOFF_CYCLES(HOLD)) u_pmicir_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .ovp_evt(ovp_evt), .uvp_evt(uvp_evt), .misc_evt(misc_evt), .diag_evt(diag_evt), .ovp_diag(ovp_diag),
    .uvp_diag(uvp_diag), .misc_diag(misc_diag), .diag_diag(diag_diag), .reset_cause(reset_cause),
    .irq_out_n(irq_out_n));
  pmicir_host u_pmicir_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_pmicir_host.rd(a, d, ok);
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("[FAIL] read answer expected 1 seen 0");
      end_of_test();
    end
    chk($sformatf("reg %h", a), exp, d);
  endtask

  task automatic wait_irq(input logic lvl, input int max);
    for (int i = 0; i < max; i++)
    begin
      if (irq_out_n === lvl)
      begin
        chk("irq_out_n", {7'h00, lvl}, {7'h00, irq_out_n});
        return;
      end
      cyc(1);
    end
    err_count++;
    $display("[FAIL] irq_out_n expected %b seen %b", lvl, irq_out_n);
    end_of_test();
  endtask

  task automatic clean();
    for (int a = 8; a < 12; a++)
      u_pmicir_host.wr(a[5:0], 8'hff);
    cyc(HOLD + 4);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int a = 3; a < 16; a++)
      rdc(a[5:0], 8'h00);
    u_pmicir_host.wr(6'h04, 8'hff);
    rdc(6'h04, 8'h00);
    chk("irq_out_n", 8'h01, {7'h00, irq_out_n});
  endtask

  task automatic t_ovp();
    ovp_evt = 7'h05;
    wait_irq(1'b0, 8);
    ovp_evt = 7'h00;
    rdc(6'h04, 8'h05);
    rdc(6'h03, 8'h01);
    u_pmicir_host.wr(6'h08, 8'h01);
    rdc(6'h04, 8'h04);
    rdc(6'h03, 8'h01);
    u_pmicir_host.wr(6'h08, 8'h04);
    rdc(6'h04, 8'h00);
    rdc(6'h03, 8'h00);
    cyc(HOLD + 4);
    chk("irq_out_n", 8'h01, {7'h00, irq_out_n});
  endtask

  task automatic t_holdoff();
    misc_evt = 7'h40;
    wait_irq(1'b0, 8);
    u_pmicir_host.wr(6'h0a, 8'h40);
    // pin stays released for the whole hold-off plus the load edge
    for (int i = 0; i < HOLD + 1; i++)
    begin
      chk("irq_out_n", 8'h01, {7'h00, irq_out_n});
      cyc(1);
    end
    wait_irq(1'b0, 2);
    misc_evt = 7'h00;
    rdc(6'h06, 8'h40);
    rdc(6'h03, 8'h04);
    clean();
  endtask

  task automatic t_mask();
    u_pmicir_host.wr(6'h0d, 8'h08);
    rdc(6'h0d, 8'h08);
    uvp_evt = 8'h08;
    cyc(3);
    uvp_evt = 8'h00;
    cyc(6);
    chk("irq_out_n", 8'h01, {7'h00, irq_out_n});
    rdc(6'h05, 8'h08);
    rdc(6'h03, 8'h02);
    u_pmicir_host.wr(6'h0d, 8'h00);
    wait_irq(1'b0, 6);
    u_pmicir_host.wr(6'h0e, 8'hff);
    rdc(6'h0e, 8'h77);
    u_pmicir_host.wr(6'h0e, 8'h00);
    clean();
    rdc(6'h05, 8'h00);
  endtask

  task automatic t_diag();
    ovp_diag = 7'h02;
    diag_evt = 7'h01;
    cyc(6);
    ovp_diag = 7'h00;
    diag_evt = 7'h00;
    rdc(6'h04, 8'h02);
    rdc(6'h07, 8'h01);
    rdc(6'h03, 8'h19);
    clean();
    rdc(6'h03, 8'h00);
  endtask

  task automatic t_cause();
    reset_cause = 1'b1;
    misc_evt = 7'h01;
    ovp_evt = 7'h10;
    cyc(6);
    reset_cause = 1'b0;
    misc_evt = 7'h00;
    ovp_evt = 7'h00;
    rdc(6'h03, 8'h25);
    u_pmicir_host.wr(6'h0a, 8'h01);
    rdc(6'h03, 8'h21);
    u_pmicir_host.wr(6'h08, 8'h10);
    rdc(6'h03, 8'h00);
    cyc(HOLD + 4);
  endtask

  task automatic t_test();
    u_pmicir_host.wr(6'h07, 8'h80);
    wait_irq(1'b0, 8);
    rdc(6'h07, 8'h80);
    rdc(6'h03, 8'h08);
    u_pmicir_host.wr(6'h07, 8'h00);
    u_pmicir_host.wr(6'h0b, 8'h80);
    cyc(HOLD + 4);
    chk("irq_out_n", 8'h01, {7'h00, irq_out_n});
    rdc(6'h03, 8'h00);
  endtask

  initial
  begin
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_ovp();
    t_holdoff();
    t_mask();
    t_diag();
    t_cause();
    t_test();
    end_of_test();
  end
endmodule
